// ===== arpp_conv_src.sv
// arpp_conv_src: converter front end model answering each start pulse.
// assumes a start pulse is one cycle; samples are base plus a 0..3 step.
`timescale 1ns/100ps
`default_nettype none
module arpp_conv_src (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_clear,
    input wire logic [3:0] i_delay,
    input wire logic [11:0] i_base,
    output logic o_valid,
    output logic [11:0] o_sample
);
    logic busy;
    logic [3:0] wait_cnt;
    logic [1:0] step;
    logic [11:0] last;
    // the step ramp makes a wrong divisor show as a wrong result
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            step <= 2'h0;
            o_valid <= 1'b0;
            last <= 12'h000;
        end else begin
            o_valid <= 1'b0;
            if (i_clear) begin
                step <= 2'h0;
            end
            if (i_start) begin
                busy <= 1'b1;
                wait_cnt <= i_delay;
            end else if (busy && wait_cnt == 4'h0) begin
                busy <= 1'b0;
                o_valid <= 1'b1;
                last <= i_base + 12'(step);
                step <= step + 2'h1;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
    // outside a valid pulse the data lines show garbage, not the old value
    assign o_sample = o_valid ? last : ~last;
endmodule : arpp_conv_src
`default_nettype wire

// ===== arpp_core.sv
// arpp_core: averaging, decimation, trim correction, window check and
// result request of a converter back end, with an APB register file.
// assumes raw samples arrive right aligned and synchronous to i_ref_clk.
// Operation
// RULE1: average configured count of consecutive samples
// RULE2: count codes 0x0..0xA are powers of two
// RULE3: automatic shift then extra shift divide
// RULE4: software sets resolution 1 before averaging
// RULE5: one result per group of raw conversions
// RULE6: ready flag only after complete average
// RULE7: software selects 16-bit mode for decimation
// RULE8: 4^n samples shifted n bits gain n bits
// RULE9: software uses fixed decimation settings table
// RULE10: compare result to window by mode field
// RULE11: thresholds signed when differential, else unsigned
// RULE12: thresholds limited to selected resolution bits
// RULE13: match flag set when window condition holds
// RULE14: corrected output is (value minus offset) times gain
// RULE15: software enables correction, else raw passes
// RULE16: correction adds thirteen cycles of latency
// RULE17: request rises on result, falls on read
// RULE18: with averaging request waits for whole group
// RULE19: resolution 8, 10, 12, 16 bits, resets 12
// RULE20: free running restarts, ready per conversion
// RULE21: writing one clears a flag, zero keeps
// RULE22: window codes none, above, below, inside, outside
// RULE23: outputs saturate to the selected resolution
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module arpp_core #(
    parameter int SAMPLE_W = 12,
    parameter int ACC_W = 24,
    parameter int LATENCY = arpp_pkg::ARPP_CORR_LATENCY
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sample_valid,
    input wire logic [SAMPLE_W-1:0] i_sample,
    output logic o_conv_start,
    output logic o_dma_req,
    output logic o_result_ready_flag,
    output logic o_window_match_flag
);
    import arpp_pkg::*;

    // software registers
    logic differential_select;
    logic free_run;
    logic correction_enable;
    logic [1:0] resolution_select;
    logic start_pulse;
    logic [3:0] sample_count_code;
    logic [2:0] extra_shift_code;
    logic [2:0] window_condition_select;
    logic [15:0] window_lower_threshold;
    logic [15:0] window_upper_threshold;
    logic [11:0] offset_trim_value;
    logic [11:0] gain_trim_value;
    logic result_ready_flag;
    logic window_match_flag;
    logic [15:0] result;
    logic dma_req;

    // datapath state
    logic [ACC_W-1:0] acc;
    logic [10:0] count;
    logic [LATENCY-1:0] pipe_valid;
    logic [15:0] pipe_data [LATENCY];

    // bus decode: one wait state so read data leaves a flip-flop
    logic access;
    logic wr_en;
    logic rd_result;
    logic mapped;
    assign access = i_psel & i_penable & o_pready;
    assign wr_en = access & i_pwrite;
    assign rd_result = access & ~i_pwrite & (i_paddr == ARPP_OFS_RESULT);

    always_comb begin
        case (i_paddr)
            ARPP_OFS_CONTROL_SECOND, ARPP_OFS_AVERAGE_CONTROL,
            ARPP_OFS_WINDOW_CONTROL, ARPP_OFS_WINDOW_LOWER,
            ARPP_OFS_WINDOW_UPPER, ARPP_OFS_OFFSET_TRIM,
            ARPP_OFS_GAIN_TRIM, ARPP_OFS_FLAG_STATUS,
            ARPP_OFS_RESULT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // group size and automatic shift from the count code
    logic code_ok;
    logic [10:0] group_last;
    logic [3:0] auto_shift;
    logic [3:0] total_shift;
    assign code_ok = (sample_count_code <= ARPP_COUNT_MAX_CODE); // see RULE2
    // reserved codes fall back to single samples, no shift
    assign group_last = code_ok ? 11'((11'h1 << sample_count_code) - 11'h1)
                                : 11'h0; // see RULE2
    assign auto_shift = (code_ok && sample_count_code > ARPP_NO_SHIFT_CODE)
                        ? 4'(sample_count_code - ARPP_NO_SHIFT_CODE)
                        : 4'h0; // see RULE3
    assign total_shift = code_ok ? 4'(auto_shift + {1'b0, extra_shift_code})
                                 : 4'h0; // see RULE3 see RULE8

    // sign or zero extend the raw sample
    logic signed [ACC_W-1:0] samp_ext;
    assign samp_ext = differential_select
        ? ACC_W'(signed'(i_sample))
        : ACC_W'({1'b0, i_sample});

    // sum of the group including the sample arriving now
    logic signed [ACC_W-1:0] group_sum;
    logic group_done;
    logic signed [ACC_W-1:0] averaged;
    assign group_sum = ACC_W'(acc + samp_ext);
    assign group_done = i_sample_valid & (count == group_last); // see RULE5
    assign averaged = group_sum >>> total_shift; // see RULE1 see RULE3

    // offset then gain correction, gain is unsigned with 11 fraction bits
    logic signed [39:0] corrected;
    logic signed [39:0] product;
    assign product = 40'((40'(averaged) - 40'(signed'(offset_trim_value)))
                     * signed'({28'h0, gain_trim_value}));
    assign corrected = correction_enable
        ? (product >>> ARPP_GAIN_FRAC_BITS)
        : 40'(averaged); // see RULE14 see RULE15

    // limits of the selected resolution
    logic [4:0] res_bits;
    always_comb begin
        case (resolution_select)
            ARPP_RES_16: res_bits = 5'd16;
            ARPP_RES_10: res_bits = 5'd10;
            ARPP_RES_8: res_bits = 5'd8;
            default: res_bits = 5'd12;
        endcase
    end // see RULE19

    logic signed [39:0] lim_hi;
    logic signed [39:0] lim_lo;
    logic [15:0] saturated;
    assign lim_hi = differential_select
        ? 40'((40'sh1 <<< (res_bits - 5'd1)) - 40'sh1)
        : 40'((40'sh1 <<< res_bits) - 40'sh1);
    assign lim_lo = differential_select
        ? 40'(-(40'sh1 <<< (res_bits - 5'd1)))
        : 40'sh0;
    // clamp rather than wrap so a trim error cannot flip the sign
    assign saturated = (corrected > lim_hi) ? lim_hi[15:0]
                     : (corrected < lim_lo) ? lim_lo[15:0]
                     : corrected[15:0]; // see RULE23

    // accumulator and group counter, restarted when the count changes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            acc <= '0;
            count <= 11'h0;
        end else if (wr_en && i_paddr == ARPP_OFS_AVERAGE_CONTROL) begin
            acc <= '0;
            count <= 11'h0;
        end else if (group_done) begin
            acc <= '0;
            count <= 11'h0;
        end else if (i_sample_valid) begin
            acc <= group_sum; // see RULE1
            count <= 11'(count + 11'h1);
        end
    end

    // fixed delay line; a steady free-running stream pays it only once
    logic pipe_in_valid;
    assign pipe_in_valid = group_done & correction_enable;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pipe_valid <= '0;
            for (int i = 0; i < LATENCY; i++) begin
                pipe_data[i] <= 16'h0000;
            end
        end else begin
            pipe_valid <= {pipe_valid[LATENCY-2:0], pipe_in_valid}; // see RULE16
            pipe_data[0] <= saturated;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_data[i] <= pipe_data[i-1];
            end
        end
    end

    // a result lands either directly or after the correction delay
    logic result_write;
    logic [15:0] result_value;
    assign result_write = (group_done & ~correction_enable)
                        | pipe_valid[LATENCY-1];
    assign result_value = pipe_valid[LATENCY-1] ? pipe_data[LATENCY-1]
                                                : saturated;

    // window thresholds trimmed to the resolution, sign taken from its top
    logic signed [17:0] win_res;
    logic signed [17:0] win_lo;
    logic signed [17:0] win_hi;
    logic [15:0] res_mask;
    assign res_mask = 16'((17'h1 << res_bits) - 17'h1); // see RULE12

    function automatic logic signed [17:0] arpp_extend(
        input logic [15:0] value,
        input logic [15:0] mask,
        input logic [4:0] bits,
        input logic is_signed
    );
        logic [15:0] kept;
        logic sign;
        kept = value & mask;
        sign = is_signed & kept[4'(bits - 5'd1)];
        arpp_extend = sign ? 18'(signed'({2'b11, kept | ~mask}))
                           : 18'(signed'({2'b00, kept}));
    endfunction : arpp_extend

    assign win_res = arpp_extend(result_value, res_mask, res_bits,
                                 differential_select); // see RULE11
    assign win_lo = arpp_extend(window_lower_threshold, res_mask, res_bits,
                                differential_select); // see RULE11
    assign win_hi = arpp_extend(window_upper_threshold, res_mask, res_bits,
                                differential_select); // see RULE12

    logic win_hit;
    always_comb begin
        case (window_condition_select)
            ARPP_WIN_ABOVE: win_hit = win_res > win_lo;
            ARPP_WIN_BELOW: win_hit = win_res < win_hi;
            ARPP_WIN_INSIDE: win_hit = (win_res > win_lo) & (win_res < win_hi);
            ARPP_WIN_OUTSIDE: win_hit = (win_res < win_lo) | (win_res > win_hi);
            default: win_hit = 1'b0;
        endcase
    end // see RULE10 see RULE22

    // result register and request; a new result beats a same-cycle read
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            result <= 16'h0000;
            dma_req <= 1'b0;
        end else begin
            if (result_write) begin
                result <= result_value;
            end
            if (result_write) begin
                dma_req <= 1'b1; // see RULE17 see RULE18
            end else if (rd_result) begin
                dma_req <= 1'b0; // see RULE17
            end
        end
    end

    // sticky flags: hardware set wins over a write-one clear
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            result_ready_flag <= 1'b0;
            window_match_flag <= 1'b0;
        end else begin
            if (result_write) begin
                result_ready_flag <= 1'b1; // see RULE6 see RULE20
            end else if (wr_en && i_paddr == ARPP_OFS_FLAG_STATUS
                         && i_pwdata[ARPP_POS_READY_FLAG]) begin
                result_ready_flag <= 1'b0; // see RULE21
            end
            if (result_write && win_hit) begin
                window_match_flag <= 1'b1; // see RULE13
            end else if (wr_en && i_paddr == ARPP_OFS_FLAG_STATUS
                         && i_pwdata[ARPP_POS_MATCH_FLAG]) begin
                window_match_flag <= 1'b0; // see RULE21
            end
        end
    end

    // configuration registers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            differential_select <= 1'b0;
            free_run <= 1'b0;
            correction_enable <= 1'b0;
            resolution_select <= ARPP_RST_RESOLUTION; // see RULE19
            sample_count_code <= 4'h0;
            extra_shift_code <= 3'h0;
            window_condition_select <= ARPP_WIN_NONE;
            window_lower_threshold <= 16'h0000;
            window_upper_threshold <= 16'h0000;
            offset_trim_value <= 12'h000;
            gain_trim_value <= ARPP_RST_GAIN;
        end else if (wr_en) begin
            case (i_paddr)
                ARPP_OFS_CONTROL_SECOND: begin
                    differential_select <= i_pwdata[ARPP_POS_DIFFERENTIAL];
                    free_run <= i_pwdata[ARPP_POS_FREE_RUN];
                    correction_enable <= i_pwdata[ARPP_POS_CORRECTION];
                    resolution_select <=
                        i_pwdata[ARPP_POS_RESOLUTION +: 2];
                end
                ARPP_OFS_AVERAGE_CONTROL: begin
                    sample_count_code <= i_pwdata[ARPP_POS_SAMPLE_COUNT +: 4];
                    extra_shift_code <= i_pwdata[ARPP_POS_EXTRA_SHIFT +: 3];
                end
                ARPP_OFS_WINDOW_CONTROL: window_condition_select <= i_pwdata[2:0];
                ARPP_OFS_WINDOW_LOWER: window_lower_threshold <= i_pwdata[15:0];
                ARPP_OFS_WINDOW_UPPER: window_upper_threshold <= i_pwdata[15:0];
                ARPP_OFS_OFFSET_TRIM: offset_trim_value <= i_pwdata[11:0];
                ARPP_OFS_GAIN_TRIM: gain_trim_value <= i_pwdata[11:0];
                default: ;
            endcase
        end
    end

    // conversion start: software pulse, or restart after each sample
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= (wr_en && i_paddr == ARPP_OFS_CONTROL_SECOND
                            && i_pwdata[ARPP_POS_START])
                         | (free_run & i_sample_valid); // see RULE20
        end
    end

    // apb answer, read data and error from flip-flops
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel & i_penable & ~o_pready;
            o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
            case (i_paddr)
                ARPP_OFS_CONTROL_SECOND: o_prdata <= 32'({resolution_select,
                    correction_enable, free_run, 1'b0, differential_select});
                ARPP_OFS_AVERAGE_CONTROL: o_prdata <= 32'({1'b0,
                    extra_shift_code, sample_count_code});
                ARPP_OFS_WINDOW_CONTROL: o_prdata <= 32'(window_condition_select);
                ARPP_OFS_WINDOW_LOWER: o_prdata <= 32'(window_lower_threshold);
                ARPP_OFS_WINDOW_UPPER: o_prdata <= 32'(window_upper_threshold);
                ARPP_OFS_OFFSET_TRIM: o_prdata <= 32'(offset_trim_value);
                ARPP_OFS_GAIN_TRIM: o_prdata <= 32'(gain_trim_value);
                ARPP_OFS_FLAG_STATUS: o_prdata <= 32'({window_match_flag,
                    result_ready_flag});
                ARPP_OFS_RESULT: o_prdata <= 32'(result);
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign o_conv_start = start_pulse;
    assign o_dma_req = dma_req;
    assign o_result_ready_flag = result_ready_flag;
    assign o_window_match_flag = window_match_flag;

endmodule : arpp_core
`default_nettype wire

// ===== arpp_core_checker.sv
// arpp_core_checker: port-level assertions for the result back end.
// assumes one clock domain and the port list of arpp_core.
`timescale 1ns/100ps
`default_nettype none
module arpp_core_checker #(
    parameter int LATENCY = 13
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_sample_valid,
    input wire logic o_dma_req,
    input wire logic o_result_ready_flag,
    input wire logic o_window_match_flag
);
    import arpp_pkg::*;
    logic done;
    logic wr_flag;
    logic rd_result;
    // completion edges of the accesses that may touch sticky state
    assign done = i_psel && i_penable && o_pready;
    assign wr_flag = done && i_pwrite && i_paddr == ARPP_OFS_FLAG_STATUS;
    assign rd_result = done && !i_pwrite && i_paddr == ARPP_OFS_RESULT;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    chk_req_has_flag: assert property ($rose(o_dma_req) |-> o_result_ready_flag)
        else $error("request rose without the ready flag");
    chk_req_after_sample: assert property ($rose(o_dma_req) |->
        $past(i_sample_valid) || $past(i_sample_valid, LATENCY + 1))
        else $error("request rose at no fixed distance from a sample");
    chk_req_holds: assert property (o_dma_req && !rd_result |=> o_dma_req)
        else $error("request dropped without a result read");
    chk_ready_sticky: assert property (
        o_result_ready_flag && !(wr_flag && i_pwdata[0]) |=> o_result_ready_flag)
        else $error("ready flag cleared without a one written");
    chk_match_sticky: assert property (
        o_window_match_flag && !(wr_flag && i_pwdata[1]) |=> o_window_match_flag)
        else $error("match flag cleared without a one written");
    chk_match_result: assert property ($rose(o_window_match_flag) |->
        o_result_ready_flag && o_dma_req)
        else $error("match flag rose without a new result");
    chk_ready_req: assert property ($rose(o_result_ready_flag) |-> o_dma_req)
        else $error("ready flag rose without the request");
    chk_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("access not answered after one wait state");
    chk_err_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error answer carried data");
endmodule : arpp_core_checker
bind arpp_core arpp_core_checker #(.LATENCY(LATENCY)) u_arpp_core_checker (
    .i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_sample_valid, .o_dma_req,
    .o_result_ready_flag, .o_window_match_flag);
`default_nettype wire

// ===== arpp_core_tb.sv
// arpp_core_tb: APB-level tests of the result back end.
// assumes arpp_conv_src supplies samples on each conversion start.
`timescale 1ns/100ps
`default_nettype none
module arpp_core_tb;
    import arpp_pkg::*;
    localparam logic [31:0] C_START = 32'h1 << ARPP_POS_START;
    localparam logic [31:0] C_FREE = 32'h1 << ARPP_POS_FREE_RUN;
    localparam logic [31:0] C_CORR = 32'h1 << ARPP_POS_CORRECTION;
    localparam logic [31:0] C_RES16 = 32'h10;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic clear = 1'b0, pready, pslverr, valid, cstart, req, rdy, win, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, sum;
    logic [3:0] delay = 4'h2;
    logic [11:0] base = 12'h000, sample;
    logic [63:0] codes = 64'h8642_BA98_7654_3210;
    logic [63:0] extras = 64'h0121_0444_4444_3210;
    int mismatches = 0, checked = 0, n, nval, code, sh;
    localparam int LATENCY_CHECK = ARPP_CORR_LATENCY + 1;
    always #10 clk = ~clk;
    // the clear pulse also restarts the sample count of a group
    always @(posedge clk) nval <= clear ? 0 : nval + int'(valid === 1'b1);
    arpp_core u_arpp_core (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sample_valid(valid), .i_sample(sample),
        .o_conv_start(cstart), .o_dma_req(req), .o_result_ready_flag(rdy),
        .o_window_match_flag(win));
    arpp_conv_src u_arpp_conv_src (.i_ref_clk(clk), .i_rst(rst),
        .i_start(cstart), .i_clear(clear), .i_delay(delay), .i_base(base),
        .o_valid(valid), .o_sample(sample));
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    // one APB transfer; holds the request until pready is seen at an edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) compare(32'h0, 32'h1);
        @(posedge clk);
    endtask : xfer
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        compare(rd, exp);
    endtask : rdchk
    task automatic wait_req;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req !== 1'b1 && n < 20000);
        if (req !== 1'b1) compare(32'h0, 32'h1);
    endtask : wait_req
    // software start, then edges from the sample to the request
    task automatic shot(input logic [31:0] ctrl, input logic [11:0] b);
        base <= b;
        clear <= 1'b1;
        xfer(ARPP_OFS_FLAG_STATUS, 1'b1, 32'h3);
        clear <= 1'b0;
        xfer(ARPP_OFS_CONTROL_SECOND, 1'b1, ctrl | C_START);
        n = 0;
        while (valid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        wait_req();
    endtask : shot
    task automatic finish_test;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(ARPP_OFS_CONTROL_SECOND, 32'h0);
        rdchk(ARPP_OFS_GAIN_TRIM, 32'h800);
        rdchk(ARPP_OFS_FLAG_STATUS, 32'h0);
        xfer(8'h40, 1'b0, 32'h0);
        compare({31'h0, err}, 32'h1);
        shot(32'h0, 12'h123);
        compare(n, 1);
        compare({31'h0, rdy}, 32'h1);
        rdchk(ARPP_OFS_RESULT, 32'h123);
        compare({31'h0, req}, 32'h0);
        xfer(ARPP_OFS_FLAG_STATUS, 1'b1, 32'h0);
        compare({31'h0, rdy}, 32'h1);
        xfer(ARPP_OFS_FLAG_STATUS, 1'b1, 32'h1);
        compare({31'h0, rdy}, 32'h0);
        $display("test basic done");
        // every window code against lower 0x100, upper 0x200, result 0x123
        xfer(ARPP_OFS_WINDOW_LOWER, 1'b1, 32'h100);
        xfer(ARPP_OFS_WINDOW_UPPER, 1'b1, 32'h200);
        for (int m = 0; m < 8; m++) begin
            xfer(ARPP_OFS_WINDOW_CONTROL, 1'b1, 32'(m));
            shot(32'h0, 12'h123);
            compare({31'h0, win}, 32'(m >= 1 && m <= 3));
            rdchk(ARPP_OFS_RESULT, 32'h123);
        end
        // differential 8-bit: upper 0x105 counts as +5, result -16
        xfer(ARPP_OFS_WINDOW_LOWER, 1'b1, 32'h0);
        xfer(ARPP_OFS_WINDOW_UPPER, 1'b1, 32'h105);
        xfer(ARPP_OFS_WINDOW_CONTROL, 1'b1, 32'(ARPP_WIN_BELOW));
        shot(32'h31, 12'hFF0);
        compare({31'h0, win}, 32'h1);
        rdchk(ARPP_OFS_RESULT, 32'hFFF0);
        xfer(ARPP_OFS_WINDOW_CONTROL, 1'b1, 32'h0);
        $display("test window done");
        xfer(ARPP_OFS_OFFSET_TRIM, 1'b1, 32'h10);
        xfer(ARPP_OFS_GAIN_TRIM, 1'b1, 32'hC00);
        shot(C_CORR, 12'h200);
        compare(n, 32'(LATENCY_CHECK));
        rdchk(ARPP_OFS_RESULT, 32'h2E8);
        shot(C_CORR, 12'h005);
        rdchk(ARPP_OFS_RESULT, 32'h0);
        xfer(ARPP_OFS_OFFSET_TRIM, 1'b1, 32'h0);
        xfer(ARPP_OFS_GAIN_TRIM, 1'b1, 32'hFFF);
        shot(C_CORR, 12'hFFF);
        rdchk(ARPP_OFS_RESULT, 32'hFFF);
        $display("test correction done");
        // averaging codes 0x0..0xB, then the four decimation settings
        delay <= 4'h9;
        for (int i = 0; i < 16; i++) begin
            code = int'(codes[i*4+:4]);
            sh = (code > 4 && code <= 10) ? code - 4 : 0;
            sh = sh + int'(extras[i*4+:4]);
            sum = 32'h0;
            for (int j = 0; j < (code > 10 ? 1 : 1 << code); j++) begin
                sum = sum + 32'h100 + 32'(j % 4);
            end
            xfer(ARPP_OFS_CONTROL_SECOND, 1'b1, C_RES16);
            repeat (14) @(posedge clk);
            xfer(ARPP_OFS_RESULT, 1'b0, 32'h0); // drop a stale request
            xfer(ARPP_OFS_AVERAGE_CONTROL, 1'b1,
                 {25'h0, extras[i*4+:3], codes[i*4+:4]});
            base <= 12'h100;
            clear <= 1'b1;
            @(posedge clk);
            clear <= 1'b0;
            xfer(ARPP_OFS_CONTROL_SECOND, 1'b1, C_RES16 | C_FREE | C_START);
            wait_req();
            compare(nval, code > 10 ? 1 : 1 << code);
            rdchk(ARPP_OFS_RESULT, sum >> sh);
        end
        $display("test averaging done");
        finish_test();
    end
endmodule : arpp_core_tb
`default_nettype wire

// ===== arpp_pkg.sv
// arpp_pkg: shared constants for the converter result post-processing block.
// assumes a 32-bit APB register bus, one word per register.
package arpp_pkg;

    // register byte offsets
    localparam logic [7:0] ARPP_OFS_CONTROL_SECOND = 8'h00;
    localparam logic [7:0] ARPP_OFS_AVERAGE_CONTROL = 8'h04;
    localparam logic [7:0] ARPP_OFS_WINDOW_CONTROL = 8'h08;
    localparam logic [7:0] ARPP_OFS_WINDOW_LOWER = 8'h0C;
    localparam logic [7:0] ARPP_OFS_WINDOW_UPPER = 8'h10;
    localparam logic [7:0] ARPP_OFS_OFFSET_TRIM = 8'h14;
    localparam logic [7:0] ARPP_OFS_GAIN_TRIM = 8'h18;
    localparam logic [7:0] ARPP_OFS_FLAG_STATUS = 8'h1C;
    localparam logic [7:0] ARPP_OFS_RESULT = 8'h20;

    // control_second fields
    localparam int ARPP_POS_DIFFERENTIAL = 0;
    localparam int ARPP_POS_START = 1;
    localparam int ARPP_POS_FREE_RUN = 2;
    localparam int ARPP_POS_CORRECTION = 3;
    localparam int ARPP_POS_RESOLUTION = 4;
    // average_control fields
    localparam int ARPP_POS_SAMPLE_COUNT = 0;
    localparam int ARPP_POS_EXTRA_SHIFT = 4;
    // flag_status fields
    localparam int ARPP_POS_READY_FLAG = 0;
    localparam int ARPP_POS_MATCH_FLAG = 1;

    // resolution_select codes
    localparam logic [1:0] ARPP_RES_12 = 2'h0;
    localparam logic [1:0] ARPP_RES_16 = 2'h1;
    localparam logic [1:0] ARPP_RES_10 = 2'h2;
    localparam logic [1:0] ARPP_RES_8 = 2'h3;

    // window_condition_select codes
    localparam logic [2:0] ARPP_WIN_NONE = 3'h0;
    localparam logic [2:0] ARPP_WIN_ABOVE = 3'h1;
    localparam logic [2:0] ARPP_WIN_BELOW = 3'h2;
    localparam logic [2:0] ARPP_WIN_INSIDE = 3'h3;
    localparam logic [2:0] ARPP_WIN_OUTSIDE = 3'h4;

    // sample count codes and automatic shift
    localparam logic [3:0] ARPP_COUNT_MAX_CODE = 4'hA;
    localparam logic [3:0] ARPP_NO_SHIFT_CODE = 4'h4;

    // reset values
    localparam logic [1:0] ARPP_RST_RESOLUTION = ARPP_RES_12;
    localparam logic [11:0] ARPP_RST_GAIN = 12'h800;
    localparam int ARPP_GAIN_FRAC_BITS = 11;

    // correction latency in converter clock cycles
    localparam int ARPP_CORR_LATENCY = 13;

endpackage : arpp_pkg
